// *** src/dbgac_top.sv ***
// Debug arm, immediate trigger and breakpoint control with bank selection
`timescale 1ns/1ps
`include "dbgac_cfg.svh"
module dbgac_top
    import dbgac_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DW-1:0] reg_rdata_out,
    input wire logic secure_in,
    input wire logic bgnd_enable_in,
    input wire logic bgnd_active_in,
    input wire logic final_state_in,
    input wire logic trace_done_in,
    input wire logic [2:0] seq_state_in,
    input wire logic [DW-1:0] seq_a_in,
    input wire logic [DW-1:0] seq_b_in,
    input wire logic [DW-1:0] seq_c_in,
    input wire logic [DW-1:0] mflag_in,
    input wire logic [DW-1:0] win_a_in,
    input wire logic [DW-1:0] win_b_in,
    input wire logic [DW-1:0] win_c_in,
    output logic armed_out,
    output logic enter_state1_out,
    output logic trigger_out,
    output logic trace_start_out,
    output logic session_end_out,
    output logic bgnd_break_out,
    output logic swi_break_out,
    output logic [2:0] win_sel_out
);
    // Only byte-wide registers are served
    if (DW != 8) begin : g_dw_check
        $error("dbgac_top: DW must be 8");
    end
    logic arm_reg;
    logic arm_next;
    logic bgnd_sel_reg;
    logic bgnd_sel_next;
    logic fbrk_en_reg;
    logic fbrk_en_next;
    logic [1:0] bank_reg;
    logic [1:0] bank_next;
    logic tsrc_reg;
    logic tsrc_next;
    logic trigger_alignment_reg;
    logic trigger_alignment_next;
    dbgac_state_t state_reg;
    dbgac_state_t state_next;
    logic immediate_trigger_request_src_reg;
    logic immediate_trigger_request_src_next;
    logic [DW-1:0] rdata_next;
    logic wr_c1;
    logic wr_tcr;
    logic rd_win;
    logic immediate_trigger_request_wr;
    logic arm_immediate_trigger_request_wr;
    logic immediate_trigger_request_fire;
    logic trace_ok;
    logic start_trace;
    logic trace_end;
    logic brk_req;
    logic brk_bgnd;
    logic brk_swi;
    logic auto_disarm;
    logic [DW-1:0] shared_val;
    logic [DW-1:0] window_val;
    logic [DW-1:0] c1_read;
    logic [DW-1:0] tcr_read;
    // Write and read-window decode
    assign wr_c1 = reg_wr_in && (reg_addr_in == `DBGAC_CTRL_ONE_OFS);
    assign wr_tcr = reg_wr_in && (reg_addr_in == `DBGAC_TRACE_OFS);
    assign rd_win = (reg_addr_in >= `DBGAC_WIN_LO) && (reg_addr_in <= `DBGAC_WIN_HI);
    assign immediate_trigger_request_wr = wr_c1 && reg_wdata_in[`DBGAC_IMMEDIATE_TRIGGER_REQUEST_BIT];
    assign arm_immediate_trigger_request_wr = immediate_trigger_request_wr && reg_wdata_in[`DBGAC_ARM_BIT];
    assign immediate_trigger_request_fire = immediate_trigger_request_wr && arm_reg && !arm_immediate_trigger_request_wr && (state_reg != DBGAC_TRACE_ST);
    // Trace permission and start
    assign trace_ok = tsrc_reg && !secure_in;
    assign start_trace = immediate_trigger_request_wr && !arm_immediate_trigger_request_wr && arm_reg && trace_ok
                         && (state_reg != DBGAC_TRACE_ST);
    assign trace_end = (state_reg == DBGAC_TRACE_ST) && trace_done_in;
    // Breakpoint request: final state while tracing is not permitted, or end of any trace
    assign brk_req = fbrk_en_reg && arm_reg &&
                     ((final_state_in && !trace_ok && state_reg != DBGAC_TRACE_ST) ||
                      trace_end);
    assign brk_bgnd = brk_req && bgnd_sel_reg && bgnd_enable_in;
    assign brk_swi = brk_req && ((bgnd_sel_reg && !bgnd_enable_in) ||
                                 (!bgnd_sel_reg && !bgnd_active_in));
    assign auto_disarm = trace_end || (brk_req && !trace_ok) || arm_immediate_trigger_request_wr;
    // Control register next values
    // Trigger-only writes leave arm as it is, so a trigger can run inside a session
    assign arm_next = auto_disarm ? 1'b0 :
                      (wr_c1 && !immediate_trigger_request_wr) ? reg_wdata_in[`DBGAC_ARM_BIT] : arm_reg;
    assign bank_next = wr_c1 ? reg_wdata_in[`DBGAC_BANK_HI:`DBGAC_BANK_LO] : bank_reg;
    assign bgnd_sel_next = (wr_c1 && !arm_reg) ? reg_wdata_in[`DBGAC_BGND_BIT] : bgnd_sel_reg;
    assign fbrk_en_next = (wr_c1 && !arm_reg) ? reg_wdata_in[`DBGAC_FBRK_BIT] : fbrk_en_reg;
    assign tsrc_next = (wr_tcr && !arm_reg && !secure_in) ? reg_wdata_in[`DBGAC_TSRC_BIT] : tsrc_reg;
    assign trigger_alignment_next = (wr_tcr && !arm_reg) ? reg_wdata_in[`DBGAC_TRIGGER_ALIGNMENT_BIT] : trigger_alignment_reg;
    // Session state machine
    always_comb begin
        state_next = state_reg;
        immediate_trigger_request_src_next = immediate_trigger_request_src_reg;
        unique case (state_reg)
            DBGAC_IDLE_ST: begin
                if (arm_next) begin
                    state_next = DBGAC_ARMED_ST;
                end
            end
            DBGAC_ARMED_ST: begin
                if (!arm_next) begin
                    state_next = DBGAC_IDLE_ST;
                end else if (start_trace) begin
                    state_next = DBGAC_TRACE_ST;
                    immediate_trigger_request_src_next = 1'b1;
                end else if (final_state_in && trace_ok) begin
                    state_next = DBGAC_TRACE_ST;
                    immediate_trigger_request_src_next = 1'b0;
                end
            end
            DBGAC_TRACE_ST: begin
                if (!arm_next || trace_end) begin
                    state_next = DBGAC_IDLE_ST;
                end
            end
            default: begin
                state_next = DBGAC_IDLE_ST;
            end
        endcase
    end
    // Read data: trigger reads zero, reserved bits zero
    assign c1_read = {arm_reg, 1'b0, 1'b0, bgnd_sel_reg, fbrk_en_reg, 1'b0, bank_reg};
    assign tcr_read = {1'b0, tsrc_reg, 5'h00, trigger_alignment_reg};
    assign rdata_next = !reg_rd_in ? `DBGAC_ZERO8 :
                        (reg_addr_in == `DBGAC_CTRL_ONE_OFS) ? c1_read :
                        (reg_addr_in == `DBGAC_STAT_OFS) ? {5'h00, seq_state_in} :
                        (reg_addr_in == `DBGAC_TRACE_OFS) ? tcr_read :
                        (reg_addr_in == `DBGAC_SHARED_OFS) ? shared_val :
                        rd_win ? window_val : `DBGAC_ZERO8;
    dbgac_bank_mux #(.DW(DW)) u_bank (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .bank_in(bank_next),
        .seq_a_in(seq_a_in),
        .seq_b_in(seq_b_in),
        .seq_c_in(seq_c_in),
        .mflag_in(mflag_in),
        .win_a_in(win_a_in),
        .win_b_in(win_b_in),
        .win_c_in(win_c_in),
        .shared_out(shared_val),
        .window_out(window_val),
        .win_sel_out(win_sel_out)
    );
    // Control registers
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            arm_reg <= 1'b0;
            bgnd_sel_reg <= 1'b0;
            fbrk_en_reg <= 1'b0;
            bank_reg <= `DBGAC_BANK_A;
            tsrc_reg <= 1'b0;
            trigger_alignment_reg <= 1'b0;
            state_reg <= DBGAC_IDLE_ST;
            immediate_trigger_request_src_reg <= 1'b0;
        end else begin
            arm_reg <= arm_next;
            bgnd_sel_reg <= bgnd_sel_next;
            fbrk_en_reg <= fbrk_en_next;
            bank_reg <= bank_next;
            tsrc_reg <= tsrc_next;
            trigger_alignment_reg <= trigger_alignment_next;
            state_reg <= state_next;
            immediate_trigger_request_src_reg <= immediate_trigger_request_src_next;
        end
    end
    // Registered outputs and pulses
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            reg_rdata_out <= '0;
            armed_out <= 1'b0;
            enter_state1_out <= 1'b0;
            trigger_out <= 1'b0;
            trace_start_out <= 1'b0;
            session_end_out <= 1'b0;
            bgnd_break_out <= 1'b0;
            swi_break_out <= 1'b0;
        end else begin
            reg_rdata_out <= rdata_next;
            armed_out <= arm_next;
            enter_state1_out <= arm_next && !arm_reg;
            trigger_out <= immediate_trigger_request_fire;
            trace_start_out <= start_trace;
            session_end_out <= arm_reg && !arm_next;
            bgnd_break_out <= brk_bgnd;
            swi_break_out <= brk_swi;
        end
    end
    // Checks
    immediate_trigger_request_reads_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        reg_rd_in && reg_addr_in == `DBGAC_CTRL_ONE_OFS |=> !reg_rdata_out[`DBGAC_IMMEDIATE_TRIGGER_REQUEST_BIT])
        else $error("trigger bit read nonzero");
    cfg_locked_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        arm_reg && wr_c1 |=> $stable(bgnd_sel_reg) && $stable(fbrk_en_reg))
        else $error("break config changed while armed");
    bank_any_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        wr_c1 |=> bank_reg == $past(reg_wdata_in[`DBGAC_BANK_HI:`DBGAC_BANK_LO]))
        else $error("bank select write lost");
    arm_state1_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !arm_reg && wr_c1 && reg_wdata_in[`DBGAC_ARM_BIT] && !immediate_trigger_request_wr |=> enter_state1_out && armed_out)
        else $error("arming did not enter state one");
    arm_immediate_trigger_request_end_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        arm_immediate_trigger_request_wr |=> !arm_reg ##0 !trace_start_out)
        else $error("arm with trigger did not end session");
    no_trace_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (secure_in || !tsrc_reg) |=> !trace_start_out)
        else $error("trace started without permission");
    immediate_trigger_request_pulse_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        trigger_out |=> !trigger_out || $past(immediate_trigger_request_wr))
        else $error("trigger held beyond write");
    immediate_trigger_request_fire_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        arm_reg && immediate_trigger_request_wr && !reg_wdata_in[`DBGAC_ARM_BIT] && (state_reg != DBGAC_TRACE_ST) |=> trigger_out)
        else $error("trigger write gave no pulse");
    brk_excl_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !(bgnd_break_out && swi_break_out))
        else $error("both breakpoint kinds raised");
    brk_enable_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !fbrk_en_reg |=> !bgnd_break_out && !swi_break_out)
        else $error("breakpoint raised while disabled");
    swi_route_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        brk_req && !bgnd_sel_reg && bgnd_active_in |=> !swi_break_out && !bgnd_break_out)
        else $error("breakpoint raised while background active");
    trace_busy_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state_reg == DBGAC_TRACE_ST) && immediate_trigger_request_wr |=> !trace_start_out && !trigger_out)
        else $error("trigger restarted running trace");
    immediate_trigger_request_brk_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        trace_end && immediate_trigger_request_src_reg && fbrk_en_reg && bgnd_sel_reg && bgnd_enable_in |=> bgnd_break_out)
        else $error("trigger trace end gave no breakpoint");
    auto_disarm_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        trace_end |=> !arm_reg)
        else $error("session end kept arm set");
endmodule

// *** include/dbgac_cfg.svh ***
// Constants for the debug arm and trigger control block
`ifndef DBGAC_CFG_SVH
`define DBGAC_CFG_SVH
`define DBGAC_ADDR_W 8
`define DBGAC_CTRL_ONE_OFS 8'h20
`define DBGAC_STAT_OFS 8'h21
`define DBGAC_TRACE_OFS 8'h22
`define DBGAC_SHARED_OFS 8'h27
`define DBGAC_WIN_LO 8'h28
`define DBGAC_WIN_HI 8'h2F
`define DBGAC_ARM_BIT 7
`define DBGAC_IMMEDIATE_TRIGGER_REQUEST_BIT 6
`define DBGAC_BGND_BIT 4
`define DBGAC_FBRK_BIT 3
`define DBGAC_BANK_HI 1
`define DBGAC_BANK_LO 0
`define DBGAC_TSRC_BIT 6
`define DBGAC_TRIGGER_ALIGNMENT_BIT 0
`define DBGAC_BANK_A 2'h0
`define DBGAC_BANK_B 2'h1
`define DBGAC_BANK_C 2'h2
`define DBGAC_BANK_NONE 2'h3
`define DBGAC_ZERO8 8'h00
`define DBGAC_WIN_IDX_W 3
`endif

// *** include/dbgac_pkg.sv ***
// Types for the debug arm and trigger control block
package dbgac_pkg;
    typedef enum logic [1:0] {
        DBGAC_IDLE_ST = 2'b00,
        DBGAC_ARMED_ST = 2'b01,
        DBGAC_TRACE_ST = 2'b10
    } dbgac_state_t;
    typedef enum logic [1:0] {
        DBGAC_BRK_NONE = 2'b00,
        DBGAC_BRK_BGND = 2'b01,
        DBGAC_BRK_SWI = 2'b10
    } dbgac_brk_t;
endpackage

// *** src/dbgac_bank_mux.sv ***
// Selector that routes the bank window and shared register by bank select
`timescale 1ns/1ps
`include "dbgac_cfg.svh"
module dbgac_bank_mux #(
    parameter int DW = 8
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [1:0] bank_in,
    input wire logic [DW-1:0] seq_a_in,
    input wire logic [DW-1:0] seq_b_in,
    input wire logic [DW-1:0] seq_c_in,
    input wire logic [DW-1:0] mflag_in,
    input wire logic [DW-1:0] win_a_in,
    input wire logic [DW-1:0] win_b_in,
    input wire logic [DW-1:0] win_c_in,
    output logic [DW-1:0] shared_out,
    output logic [DW-1:0] window_out,
    output logic [2:0] win_sel_out
);
    // Narrower words cannot carry the byte-wide registers
    if (DW < 8) begin : g_dw_check
        $error("dbgac_bank_mux: DW must be at least 8");
    end
    logic [DW-1:0] shared_next;
    logic [DW-1:0] window_next;
    logic [2:0] sel_next;
    // Bank decode: shared register and window contents
    assign shared_next = (bank_in == `DBGAC_BANK_A) ? seq_a_in :
                         (bank_in == `DBGAC_BANK_B) ? seq_b_in :
                         (bank_in == `DBGAC_BANK_C) ? seq_c_in : mflag_in;
    assign window_next = (bank_in == `DBGAC_BANK_A) ? win_a_in :
                         (bank_in == `DBGAC_BANK_B) ? win_b_in :
                         (bank_in == `DBGAC_BANK_C) ? win_c_in : '0;
    assign sel_next = (bank_in == `DBGAC_BANK_NONE) ? 3'h0 : {1'b0, bank_in} + 3'h1;
    // Registered outputs
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            shared_out <= '0;
            window_out <= '0;
            win_sel_out <= 3'h0;
        end else begin
            shared_out <= shared_next;
            window_out <= window_next;
            win_sel_out <= sel_next;
        end
    end
endmodule

// *** tb/dbgac_partner.sv ***
// Stand-in for the state sequencer and trace buffer around the control block
`timescale 1ns/1ps
module dbgac_partner #(
    parameter int TRACE_LEN = 5
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic armed_in,
    input wire logic trace_start_in,
    input wire logic goal_in,
    output logic final_state_out,
    output logic trace_done_out,
    output logic [2:0] seq_state_out
);
    logic [3:0] cnt_reg;
    // Sequencer reaches its final state only while armed; state one after arming
    assign final_state_out = armed_in && goal_in;
    assign seq_state_out = !armed_in ? 3'h0 : (goal_in ? 3'h4 : 3'h1);
    // Trace length counter; completion is a single-cycle pulse
    always_ff @(posedge mclk_in) begin
        if (reset_in || trace_start_in) begin
            cnt_reg <= reset_in ? 4'h0 : 4'(TRACE_LEN);
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
    assign trace_done_out = (cnt_reg == 4'h1);
endmodule

// *** tb/dbgac_top_tb.sv ***
// Self-checking bench for the debug arm and trigger control block
`timescale 1ns/1ps
module dbgac_top_tb;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic secure = 1'b0;
    logic bg_en = 1'b0;
    logic bg_act = 1'b0;
    logic goal = 1'b0;
    logic [7:0] vals [0:6];
    logic [7:0] rdata;
    logic [2:0] wsel;
    logic [2:0] sstate;
    logic armed, st1, immediate_trigger_request, tstart, send, bbrk, sbrk, fstate, tdone;
    int error_cnt = 0;
    int comparisons = 0;
    // Clock and start-up values
    always #5 mclk_in = ~mclk_in;
    initial for (int i = 0; i < 7; i++) vals[i] = 8'(8'h11 * (i + 1));
    dbgac_top u_dbgac_top (.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .secure_in(secure), .bgnd_enable_in(bg_en),
        .bgnd_active_in(bg_act), .final_state_in(fstate), .trace_done_in(tdone), .seq_state_in(sstate),
        .seq_a_in(vals[0]), .seq_b_in(vals[1]), .seq_c_in(vals[2]), .mflag_in(vals[3]), .win_a_in(vals[4]),
        .win_b_in(vals[5]), .win_c_in(vals[6]), .armed_out(armed), .enter_state1_out(st1), .trigger_out(immediate_trigger_request),
        .trace_start_out(tstart), .session_end_out(send), .bgnd_break_out(bbrk), .swi_break_out(sbrk),
        .win_sel_out(wsel));
    dbgac_partner u_dbgac_partner (.mclk_in(mclk_in), .reset_in(reset_in), .armed_in(armed),
        .trace_start_in(tstart), .goal_in(goal), .final_state_out(fstate), .trace_done_out(tdone),
        .seq_state_out(sstate));
    // Shared compare, bus cycles and closing report
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic tick;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic test_done;
        $display("Summary: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset values and an unmapped read
    task automatic t_reset;
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h30, 8'h00);
        check({7'h00, armed}, 8'h00);
        $display("test reset done");
    endtask
    // Config bits locked while armed, kept over a disarm write
    task automatic t_config;
        wr_reg(8'h20, 8'h5b);
        rd_chk(8'h20, 8'h1b);
        wr_reg(8'h20, 8'h9b);
        check({6'h00, armed, st1}, 8'h03);
        rd_chk(8'h21, 8'h01);
        wr_reg(8'h20, 8'h81);
        rd_chk(8'h20, 8'h99);
        wr_reg(8'h22, 8'h41);
        rd_chk(8'h22, 8'h00);
        wr_reg(8'h20, 8'h01);
        check({6'h00, armed, send}, 8'h01);
        rd_chk(8'h20, 8'h19);
        wr_reg(8'h20, 8'h00);
        rd_chk(8'h20, 8'h00);
        $display("test config done");
    endtask
    // Immediate trigger, begin-aligned trace and forced break at trace end
    task automatic t_trace;
        int n;
        wr_reg(8'h20, 8'h80);
        wr_reg(8'h20, 8'h40);
        check({6'h00, immediate_trigger_request, tstart}, 8'h02);
        wr_reg(8'h20, 8'h00);
        wr_reg(8'h22, 8'h41);
        rd_chk(8'h22, 8'h41);
        bg_en <= 1'b1;
        wr_reg(8'h20, 8'h98);
        wr_reg(8'h20, 8'h58);
        check({6'h00, immediate_trigger_request, tstart}, 8'h03);
        tick();
        check({7'h00, immediate_trigger_request}, 8'h00);
        wr_reg(8'h20, 8'h58);
        check({6'h00, immediate_trigger_request, tstart}, 8'h00);
        n = 0;
        while (bbrk !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        if (bbrk !== 1'b1) begin
            $display("Error at %0t: got %h expected %h", $time, bbrk, 1'b1);
            error_cnt++;
            test_done();
        end
        check({6'h00, bbrk, sbrk}, 8'h02);
        tick();
        check({7'h00, armed}, 8'h00);
        wr_reg(8'h20, 8'h00);
        wr_reg(8'h22, 8'h00);
        $display("test trace done");
    endtask
    // Final-state break without tracing, each break routing case
    task automatic t_final;
        logic [7:0] cfg [0:4] = '{8'h08, 8'h08, 8'h18, 8'h18, 8'h10};
        logic [1:0] env [0:4] = '{2'b00, 2'b11, 2'b00, 2'b10, 2'b10};
        logic [1:0] exp [0:4] = '{2'b01, 2'b00, 2'b01, 2'b10, 2'b00};
        logic [1:0] got;
        for (int i = 0; i < 5; i++) begin
            bg_en <= env[i][1];
            bg_act <= env[i][0];
            wr_reg(8'h20, cfg[i]);
            wr_reg(8'h20, 8'h80 | cfg[i]);
            goal <= 1'b1;
            got = 2'b00;
            repeat (4) begin
                tick();
                got = got | {bbrk, sbrk};
            end
            check({6'h00, got}, {6'h00, exp[i]});
            // A final-state break request without tracing disarms, even if routing raises none
            check({7'h00, armed}, {7'h00, !cfg[i][3]});
            goal <= 1'b0;
            wr_reg(8'h20, 8'h00);
        end
        bg_en <= 1'b0;
        bg_act <= 1'b0;
        $display("test final done");
    endtask
    // Secured part starts no trace; trigger with arm ends the session
    task automatic t_secure;
        secure <= 1'b1;
        wr_reg(8'h22, 8'h41);
        rd_chk(8'h22, 8'h01);
        wr_reg(8'h20, 8'h80);
        wr_reg(8'h20, 8'h40);
        check({7'h00, tstart}, 8'h00);
        wr_reg(8'h20, 8'hc0);
        check({5'h00, immediate_trigger_request, send, armed}, 8'h02);
        secure <= 1'b0;
        wr_reg(8'h22, 8'h00);
        $display("test secure done");
    endtask
    // Bank select while armed: window selector, shared and window reads
    task automatic t_banks;
        logic [2:0] sel [0:3] = '{3'h1, 3'h2, 3'h3, 3'h0};
        wr_reg(8'h20, 8'h80);
        for (int b = 0; b < 4; b++) begin
            wr_reg(8'h20, 8'h80 | 8'(b));
            check({5'h00, wsel}, {5'h00, sel[b]});
            rd_chk(8'h20, 8'h80 | 8'(b));
            rd_chk(8'h27, vals[b]);
            rd_chk(8'h28, (b < 3) ? vals[b + 4] : 8'h00);
        end
        wr_reg(8'h20, 8'h00);
        $display("test banks done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk_in);
        reset_in <= 1'b0;
        #1;
        t_reset();
        t_config();
        t_trace();
        t_final();
        t_secure();
        t_banks();
        test_done();
    end
endmodule
